// File: rtl/pfr_fault_reporter.sv
// Fault supervision, display and start-up sequencing.
// Assumes inputs synchronous to aclk; software on AXI4-Lite.
//
// The AXI4-Lite register port and the register addresses are this design's own decisions.
`default_nettype none

module pfr_fault_reporter
    import pfr_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC    // Cycles per ms tick
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite slave
    input  wire logic [4:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [4:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Fault causes
    input  wire logic        hw_fail,
    input  wire logic        rom_fail,
    input  wire logic        ram_fail,
    input  wire logic        serial_fail,
    input  wire logic        serial_model,
    input  wire logic        cfg_parity_off,
    input  wire logic        parity_err,
    input  wire logic        rx_overflow,
    input  wire logic        rx_nearly_full,
    input  wire logic        carriage_drive,
    input  wire logic        motion_pulse,
    input  wire logic        home_sensor,
    input  wire logic        paper_present,
    input  wire logic        line_done,
    // Handshakes and buttons
    input  wire logic        diag_done,
    input  wire logic        selftest_done,
    input  wire logic        clear_button,
    input  wire logic        master_reset_button,
    // Panel and display
    output logic             fault_lamp,
    output logic [3:0]       fault_code,
    output logic             code_shown,
    output logic             bell,
    // Printer control
    output logic             print_inhibit,
    output logic             printer_busy,
    output logic             host_connected_state,
    output logic             diag_run,
    output logic             selftest_run,
    output logic             carriage_home_cmd,
    output logic             carriage_retry,
    output logic             tone,
    output logic             load_settings,
    output logic             char_buf_clear
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    pfr_state_t  s;           // Registered state
    pfr_state_t  next_s;      // Next state
    pfr_status_t stat;        // Status word view

    // Top posted fault to its digit
    function automatic logic [4:0] pick_code(input logic [NF-1:0] p);
        logic [4:0] r;
        r = 5'h00;
        if (p[F_OVF])   r = {1'b1, CODE_OVF};
        if (p[F_PAPER]) r = {1'b1, CODE_PAPER};
        if (p[F_STALL]) r = {1'b1, CODE_STALL};
        if (p[F_PAR])   r = {1'b1, CODE_PAR};
        if (p[F_SER])   r = {1'b1, CODE_SER};
        if (p[F_RAM])   r = {1'b1, CODE_RAM};
        if (p[F_ROM])   r = {1'b1, CODE_ROM};
        if (p[F_HW])    r = {1'b1, CODE_HW};
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Bus handshakes
    // ------------------------------------------------------------------
    assign s_axi_awready = !s.aw_have && !s.bvalid;
    assign s_axi_wready  = !s.w_have && !s.bvalid;
    assign s_axi_arready = !s.rvalid;
    assign s_axi_bvalid  = s.bvalid;
    assign s_axi_bresp   = s.bresp;
    assign s_axi_rvalid  = s.rvalid;
    assign s_axi_rdata   = s.rdata;
    assign s_axi_rresp   = s.rresp;

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign fault_lamp           = s.lamp;
    assign fault_code           = s.code;
    assign code_shown           = s.shown;
    assign bell                 = s.bell;
    assign print_inhibit        = (|s.pend) || s.paper_off || (s.phase != PH_RUN);  // RL1
    assign printer_busy         = print_inhibit || rx_nearly_full;                  // RL11
    assign host_connected_state = (s.phase == PH_RUN) && !s.off_req && !s.paper_off;
    assign diag_run             = (s.phase == PH_DIAG);                             // RL12
    assign selftest_run         = (s.phase == PH_SELFTEST);
    assign carriage_home_cmd    = (s.phase == PH_MR_HOME);                          // RL14
    assign carriage_retry       = s.retry;
    assign tone                 = s.tone;
    assign load_settings        = s.load_set;
    assign char_buf_clear       = s.buf_clear;

    // Status word
    always_comb begin
        stat         = '0;
        stat.phase   = s.phase;
        stat.offline = !host_connected_state;
        stat.shown   = s.shown;
        stat.code    = s.code;
        stat.lamp    = s.lamp;
        stat.pend    = s.pend;
    end

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        logic          wr_go;      // Both write halves held
        logic          cmd_wr;     // Command write
        logic          clr;        // Fault clear
        logic          st_go;      // Self-test request
        logic          mr_go;      // Master reset request
        logic [NF-1:0] set_v;      // New faults
        logic [NF-1:0] hold_v;     // Level causes
        logic [4:0]    pc;         // Picked code
        logic [3:0]    nd;         // Next digit
        logic          ns;         // Next shown
        wr_go  = 1'b0;
        cmd_wr = 1'b0;
        clr    = 1'b0;
        st_go  = 1'b0;
        mr_go  = 1'b0;
        set_v  = '0;
        hold_v = '0;
        pc     = 5'h00;
        nd     = 4'h0;
        ns     = 1'b0;
        next_s = s;
        next_s.bell      = 1'b0;
        next_s.tone      = 1'b0;
        next_s.load_set  = 1'b0;
        next_s.buf_clear = 1'b0;
        next_s.retry     = 1'b0;

        // Millisecond enable
        next_s.tick = 1'b0;
        if (s.tick_cnt >= 17'(TICK_CYCLES - 1)) begin
            next_s.tick_cnt = '0;
            next_s.tick     = 1'b1;
        end else begin
            next_s.tick_cnt = s.tick_cnt + 17'h00001;
        end

        // Write halves taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            next_s.aw_have = 1'b1;
            next_s.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_s.w_have = 1'b1;
            next_s.wdata  = s_axi_wdata;
            next_s.wstrb  = s_axi_wstrb;
        end
        wr_go = s.aw_have && s.w_have;
        if (wr_go) begin
            next_s.aw_have = 1'b0;
            next_s.w_have  = 1'b0;
            next_s.bvalid  = 1'b1;
            next_s.bresp   = RESP_OKAY;
            unique case (s.aw_addr)
                ADDR_CTRL: begin
                    if (s.wstrb[0]) begin
                        next_s.par_en  = s.wdata[CTRL_PAR_EN];
                        next_s.off_req = s.wdata[CTRL_OFFLINE];
                    end
                end
                ADDR_CMD:    cmd_wr = s.wstrb[0];
                ADDR_STATUS: ; // Read-only
                default:     next_s.bresp = RESP_SLVERR; // Unmapped
            endcase
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end

        // Read channel
        if (s_axi_arvalid && s_axi_arready) begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = RESP_OKAY;
            unique case (s_axi_araddr)
                ADDR_CTRL:   next_s.rdata = {30'h0, s.off_req, s.par_en};
                ADDR_CMD:    next_s.rdata = 32'h00000000;
                ADDR_STATUS: next_s.rdata = stat;
                default: begin
                    next_s.rdata = 32'h00000000;
                    next_s.rresp = RESP_SLVERR;
                end
            endcase
        end else if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end

        // Command strobes
        clr   = clear_button || (cmd_wr && s.wdata[CMD_CLEAR]);
        st_go = cmd_wr && s.wdata[CMD_SELFTEST];
        mr_go = master_reset_button || (cmd_wr && s.wdata[CMD_MRESET]);

        // Carriage watchdog
        if (motion_pulse || !carriage_drive) begin
            next_s.stall_ms = '0;
            if (motion_pulse) begin
                next_s.miss = 1'b0;
            end
        end else if (s.tick) begin
            if (s.stall_ms >= STALL_MS - 16'h0001) begin
                next_s.stall_ms = '0;
                if (!s.miss) begin
                    next_s.miss  = 1'b1;           // RL16
                    next_s.retry = 1'b1;
                end else begin
                    next_s.miss         = 1'b0;
                    set_v[F_STALL]      = 1'b1;    // RL8
                    next_s.lamp         = 1'b1;    // RL16
                end
            end else begin
                next_s.stall_ms = s.stall_ms + 16'h0001;
            end
        end

        // Paper out: line, offline, lamp, code
        if (!paper_present && !s.paper_off) begin
            next_s.paper_wait = 1'b1;
        end
        if ((s.paper_wait || !paper_present) && !s.paper_off && line_done) begin
            next_s.paper_wait = 1'b0;
            next_s.paper_off  = 1'b1;              // RL15
            next_s.lamp       = 1'b1;              // RL15
        end
        set_v[F_PAPER] = s.paper_off && !paper_present;  // RL9

        // Other fault causes
        set_v[F_HW]  = hw_fail;                    // RL6
        set_v[F_ROM] = rom_fail;                   // RL6
        set_v[F_RAM] = ram_fail;                   // RL6
        set_v[F_SER] = serial_fail && serial_model;  // RL6
        set_v[F_PAR] = parity_err && s.par_en && !cfg_parity_off;  // RL7
        set_v[F_OVF] = rx_overflow;                // RL11

        // Clear keeps level causes; set wins
        hold_v[F_HW]    = hw_fail;
        hold_v[F_ROM]   = rom_fail;
        hold_v[F_RAM]   = ram_fail;
        hold_v[F_SER]   = serial_fail && serial_model;
        hold_v[F_PAPER] = !paper_present;
        next_s.pend = (clr ? (s.pend & hold_v) : s.pend) | set_v;  // RL17
        if (clr && paper_present) begin
            next_s.paper_off  = 1'b0;
            next_s.paper_wait = 1'b0;
        end
        if (|set_v) begin
            next_s.lamp = 1'b1;                    // RL2
        end else if (clr && (next_s.pend == '0) && !next_s.paper_off) begin
            next_s.lamp = 1'b0;                    // RL3
        end

        // Sequencer
        unique case (s.phase)
            PH_DIAG: begin
                if (diag_done) begin
                    next_s.phase = PH_RUN;         // RL12
                    next_s.ok_show = (next_s.pend == '0);  // RL10
                    next_s.ok_ms   = '0;
                end
            end
            PH_RUN: begin
                if (st_go && !host_connected_state) begin
                    next_s.phase = PH_SELFTEST;    // RL13
                end
            end
            PH_SELFTEST: begin
                if (selftest_done) begin
                    next_s.phase = PH_RUN;
                end
            end
            PH_MR_HOME: begin
                if (home_sensor) begin
                    next_s.phase = PH_MR_TONE;     // RL14
                    next_s.tone  = 1'b1;
                end
            end
            PH_MR_TONE: begin
                next_s.phase    = PH_MR_LOAD;
                next_s.load_set = 1'b1;            // RL14
            end
            PH_MR_LOAD: begin
                next_s.phase     = PH_MR_CLEAR;
                next_s.buf_clear = 1'b1;           // RL14
            end
            PH_MR_CLEAR: next_s.phase = PH_RUN;
        endcase
        if (mr_go && (s.phase != PH_DIAG)) begin
            next_s.phase   = PH_MR_HOME;           // RL14
            next_s.ok_show = 1'b0;
        end

        // Healthy code times out
        if (s.ok_show) begin
            if (next_s.pend != '0) begin
                next_s.ok_show = 1'b0;
            end else if (s.tick) begin
                if (s.ok_ms >= OK_SHOW_MS - 16'h0001) begin
                    next_s.ok_show = 1'b0;         // RL10
                end else begin
                    next_s.ok_ms = s.ok_ms + 16'h0001;
                end
            end
        end

        // Display and bell
        pc = pick_code(next_s.pend);
        if (pc[4]) begin
            nd = pc[3:0];                          // RL4
            ns = 1'b1;
        end else if (next_s.ok_show) begin
            nd = CODE_OK;
            ns = 1'b1;
        end
        next_s.code  = ns ? nd : s.code;
        next_s.shown = ns;
        next_s.bell  = ns && (!s.shown || (nd != s.code));  // RL5
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s        <= '0;
            s.phase  <= PH_DIAG;
            s.par_en <= CTRL_PAR_EN_RST;
        end else begin
            s <= next_s;
        end
    end

endmodule // pfr_fault_reporter

`default_nettype wire

// File: common/pfr_pkg.sv
// Constants and types of the fault reporter.
// Assumes one 125 MHz clock, synchronous active-low reset.
//
// Summary of operation
// RL1 - Any posted fault inhibits printing until cleared.
// RL2 - Fault lamp lights when operator action is needed.
// RL3 - Clear button darkens lamp once causes are gone.
// RL4 - Detected faults show a single-digit code.
// RL5 - Each display update sounds the bell once.
// RL6 - Hardware 0, ROM own code, RAM 2, serial 3.
// RL7 - Parity error is code 4 when enabled.
// RL8 - Carriage stall from missing motion is code 5.
// RL9 - Paper run out is code 7.
// RL10 - Code 8 shown briefly as healthy, never held.
// RL11 - Overflow is code 9; host honours busy.
// RL12 - Power-on diagnostic runs and posts its faults.
// RL13 - Self-test may start only while offline.
// RL14 - Master reset homes, tones, loads settings, empties buffer.
// RL15 - Paper out: finish line, offline, lamp, then code.
// RL16 - One carriage retry before declaring a stall.
// RL17 - Code 6 never shown; code held until clear.
`default_nettype none

package pfr_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;          // 125 MHz system clock
    localparam int TICK_NS       = 1000000;    // Millisecond time base
    localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
    localparam logic [15:0] OK_SHOW_MS = 16'h07D0;  // Healthy code shown 2000 ms
    localparam logic [15:0] STALL_MS   = 16'h0032;  // Motion lost after 50 ms

    // ------------------------------------------------------------------
    // Register map (byte addresses) and fields
    // ------------------------------------------------------------------
    localparam logic [4:0] ADDR_CTRL   = 5'h00;  // Settings
    localparam logic [4:0] ADDR_CMD    = 5'h04;  // Strobes
    localparam logic [4:0] ADDR_STATUS = 5'h08;  // Status
    localparam int CTRL_PAR_EN   = 0;            // Parity report
    localparam int CTRL_OFFLINE  = 1;            // Offline request
    localparam int CMD_CLEAR     = 0;            // Clear
    localparam int CMD_SELFTEST  = 1;            // Self-test
    localparam int CMD_MRESET    = 2;            // Master reset
    localparam logic CTRL_PAR_EN_RST = 1'b1;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------------
    // Fault slots and their display codes
    // ------------------------------------------------------------------
    localparam int NF = 8;
    localparam int F_HW = 0, F_ROM = 1, F_RAM = 2, F_SER = 3;
    localparam int F_PAR = 4, F_STALL = 5, F_PAPER = 6, F_OVF = 7;
    localparam logic [3:0] CODE_HW    = 4'h0;
    localparam logic [3:0] CODE_ROM   = 4'h1;
    localparam logic [3:0] CODE_RAM   = 4'h2;
    localparam logic [3:0] CODE_SER   = 4'h3;
    localparam logic [3:0] CODE_PAR   = 4'h4;
    localparam logic [3:0] CODE_STALL = 4'h5;
    localparam logic [3:0] CODE_PAPER = 4'h7;
    localparam logic [3:0] CODE_OK    = 4'h8;
    localparam logic [3:0] CODE_OVF   = 4'h9;

    // Sequencer phases
    typedef enum logic [2:0] {
        PH_DIAG, PH_RUN, PH_SELFTEST, PH_MR_HOME, PH_MR_TONE, PH_MR_LOAD, PH_MR_CLEAR
    } pfr_phase_t;

    // Status register layout
    typedef struct packed {
        logic [10:0]   zero;      // Reads as zero
        pfr_phase_t    phase;     // Sequencer phase
        logic          offline;   // Not connected to host
        logic          shown;     // Digit lit
        logic [3:0]    code;      // Displayed digit
        logic          lamp;      // Panel fault lamp
        logic [2:0]    zero2;     // Reads as zero
        logic [NF-1:0] pend;      // Posted faults
    } pfr_status_t;

    // Whole state of the block
    typedef struct packed {
        pfr_phase_t    phase;
        logic [NF-1:0] pend;
        logic          lamp;
        logic          paper_wait;
        logic          paper_off;
        logic [3:0]    code;
        logic          shown;
        logic          bell;
        logic          tone;
        logic          load_set;
        logic          buf_clear;
        logic          retry;
        logic          miss;
        logic [15:0]   stall_ms;
        logic [15:0]   ok_ms;
        logic          ok_show;
        logic [16:0]   tick_cnt;
        logic          tick;
        logic          par_en;
        logic          off_req;
        logic          aw_have;
        logic [4:0]    aw_addr;
        logic          w_have;
        logic [31:0]   wdata;
        logic [3:0]    wstrb;
        logic          bvalid;
        logic [1:0]    bresp;
        logic          rvalid;
        logic [31:0]   rdata;
        logic [1:0]    rresp;
    } pfr_state_t;

endpackage : pfr_pkg

`default_nettype wire

// File: test/pfr_fault_reporter_assertions.sv
// Checker: lamp, display, bell and sequencing.
// Assumes binding to pfr_fault_reporter; all on aclk.
`default_nettype none

module pfr_fault_reporter_checker (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       hw_fail,
    input wire logic       fault_lamp,
    input wire logic [3:0] fault_code,
    input wire logic       code_shown,
    input wire logic       bell,
    input wire logic       print_inhibit,
    input wire logic       printer_busy,
    input wire logic       host_connected_state,
    input wire logic       diag_run,
    input wire logic       selftest_run,
    input wire logic       tone,
    input wire logic       load_settings,
    input wire logic       char_buf_clear
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Master reset steps after the tone
    sequence s_mr_tail;
        ##1 load_settings ##1 char_buf_clear;
    endsequence

    AST_LAMP_SET: assert property (hw_fail |=> fault_lamp)
        else $error("lamp not lit by a failure");
    AST_HW_CODE: assert property (hw_fail |=> code_shown && fault_code == 4'h0)
        else $error("hardware failure code missing");
    AST_INHIBIT: assert property (fault_lamp |-> print_inhibit)
        else $error("printing not inhibited under fault");
    AST_NO_SIX: assert property (code_shown |-> fault_code != 4'h6)
        else $error("reserved code shown");
    AST_BELL: assert property ((code_shown && (!$past(code_shown)
        || fault_code != $past(fault_code))) |-> bell) else $error("update without bell");
    AST_MR_SEQ: assert property (tone |-> s_mr_tail)
        else $error("master reset steps out of order");
    AST_DIAG: assert property (diag_run |-> print_inhibit && !host_connected_state)
        else $error("host_connected_state during diagnostic");
    AST_SELFTEST: assert property ($rose(selftest_run) |-> !$past(host_connected_state))
        else $error("self-test started host_connected_state");
    AST_BUSY: assert property (print_inhibit |-> printer_busy)
        else $error("busy low while inhibited");
endmodule // pfr_fault_reporter_checker

bind pfr_fault_reporter pfr_fault_reporter_checker i_chk (.*);

`default_nettype wire

// File: test/pfr_host_model.sv
// Host model: fills a small receive buffer.
// Assumes one character drained per fourth cycle.
`default_nettype none

module pfr_host_model #(
    parameter int DEPTH = 8        // Buffer size
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic printer_busy,
    input  wire logic rude,        // Ignore busy
    output logic      rx_nearly_full,
    output logic      rx_overflow
);
    timeunit 1ns;
    timeprecision 1ns;
    int         cnt;               // Fill level
    logic [1:0] ph;                // Drain pacing
    logic       send;              // Offer

    assign send = rude || !printer_busy;
    assign rx_nearly_full = cnt >= DEPTH - 2;

    // Fill, drain, flag overflow
    always @(posedge aclk) begin
        if (!aresetn) begin
            cnt <= 0;
            ph <= 2'h0;
            rx_overflow <= 1'b0;
        end else begin
            ph <= ph + 2'h1;
            rx_overflow <= send && cnt == DEPTH;
            cnt <= cnt + int'(send && cnt < DEPTH) - int'(ph == 2'h0 && cnt > 0);
        end
    end
endmodule // pfr_host_model

`default_nettype wire

// File: test/pfr_fault_reporter_tb_top.sv
// Testbench: bus, fault codes and sequencing.
// Assumes the host model and a 10-cycle tick.
`default_nettype none

module pfr_fault_reporter_tb_top
    import pfr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, rx_nearly_full, rx_overflow, rude, cfg_parity_off, paper_present;
    logic [4:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb, lvl, fault_code;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [5:0] ev;
    logic fault_lamp, code_shown, bell, print_inhibit, printer_busy, host_connected_state;
    logic diag_run, selftest_run, carriage_home_cmd, carriage_retry, tone, load_settings;
    logic char_buf_clear, carriage_drive, home_sensor;
    int n_errors = 0, checks_done = 0, n;

    pfr_fault_reporter #(.TICK_CYCLES(10)) i_dut (.hw_fail(lvl[0]), .rom_fail(lvl[1]),
        .ram_fail(lvl[2]), .serial_fail(lvl[3]), .serial_model(1'b1), .parity_err(ev[0]),
        .clear_button(ev[1]), .line_done(ev[2]), .master_reset_button(ev[3]),
        .diag_done(ev[4]), .selftest_done(ev[5]), .motion_pulse(1'b0), .*);
    pfr_host_model i_host (.*);

    always #4 aclk = ~aclk;

    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %0h want %0h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge aclk);
    endtask

    // One-cycle input pulse
    task automatic pulse(input int b);
        ev <= 6'h01 << b;
        @(posedge aclk);
        ev <= 6'h00;
    endtask

    // Wait for a digit to be lit, bounded
    task automatic wcode(input logic [3:0] c);
        n = 0;
        while (!(code_shown === 1'b1 && fault_code === c) && n < 50) begin
            @(posedge aclk);
            n++;
        end
        chk(n < 50, 1);
    endtask

    task automatic clr;
        pulse(1);
        cyc(3);
        chk(fault_lamp, 0);
    endtask

    // Bus write: both halves offered, each dropped when taken
    task automatic wr(input logic [4:0] a, input logic [31:0] v);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
    endtask

    task automatic rd(input logic [4:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask

    task automatic t_boot;
        rd(ADDR_CTRL);
        chk(d, 32'h1);
        rd(ADDR_STATUS);
        chk(d[20:18], 0);
        chk(printer_busy, 1);
        pulse(4);
        wcode(CODE_OK);
        $display("boot test ended");
    endtask

    task automatic t_codes;
        for (int i = 0; i < 4; i++) begin
            lvl <= 4'h1 << i;
            wcode(4'(i));
            chk(fault_lamp, 1);
            chk(print_inhibit, 1);
            lvl <= 4'h0;
            cyc(5);
            chk(fault_code, i);
            clr;
        end
        pulse(0);
        wcode(CODE_PAR);
        clr;
        cfg_parity_off <= 1'b1;
        pulse(0);
        cyc(3);
        chk(code_shown && fault_code == CODE_PAR, 0);
        cfg_parity_off <= 1'b0;
        rude <= 1'b1;
        wcode(CODE_OVF);
        rude <= 1'b0;
        cyc(2);
        clr;
        $display("code test ended");
    endtask

    task automatic t_paper;
        paper_present <= 1'b0;
        cyc(4);
        chk(fault_lamp, 0);
        pulse(2);
        cyc(1);
        chk(fault_lamp, 1);
        chk(code_shown && fault_code == CODE_PAPER, 0);
        wcode(CODE_PAPER);
        chk(host_connected_state, 0);
        paper_present <= 1'b1;
        clr;
        $display("paper test ended");
    endtask

    task automatic t_stall;
        carriage_drive <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            n = 0;
            while (!(k ? code_shown && fault_code == CODE_STALL : carriage_retry) && n < 900)
            begin
                @(posedge aclk);
                n++;
            end
            chk(n >= 480 && n <= 530, 1);
        end
        chk(fault_lamp, 1);
        carriage_drive <= 1'b0;
        clr;
        $display("stall test ended");
    endtask

    task automatic t_seq;
        wr(ADDR_CMD, 2);
        cyc(2);
        chk(selftest_run, 0);
        wr(ADDR_CTRL, 3);
        wr(ADDR_CMD, 2);
        cyc(2);
        chk(selftest_run, 1);
        pulse(5);
        cyc(2);
        wr(ADDR_CTRL, 1);
        for (int k = 0; k < 2; k++) begin
            home_sensor <= 1'b0;
            if (k == 0) wr(ADDR_CMD, 4);
            else pulse(3);
            cyc(2);
            chk(carriage_home_cmd, 1);
            home_sensor <= 1'b1;
            n = 0;
            while (!char_buf_clear && n < 20) begin
                @(posedge aclk);
                n++;
            end
            chk(n < 20, 1);
            cyc(2);
            chk(host_connected_state, 1);
        end
        rd(5'h1C);
        chk(r, RESP_SLVERR);
        chk(d, 0);
        $display("sequence test ended");
    endtask

    initial begin
        aclk = 0;
        aresetn = 0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, lvl, ev} = '0;
        s_axi_wstrb = 4'hF;
        {rude, cfg_parity_off, carriage_drive, home_sensor} = '0;
        {s_axi_bready, s_axi_rready, paper_present} = 3'h7;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_boot;
        t_codes;
        t_paper;
        t_stall;
        t_seq;
        conclude;
    end

    // Cut a hang short
    initial begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        conclude;
    end
endmodule // pfr_fault_reporter_tb_top

`default_nettype wire
